// file: inc/ctirq_defines.vh
// register offsets, field positions, reset values and timing counts of the charger timer block
`ifndef CTIRQ_DEFINES_VH
`define CTIRQ_DEFINES_VH
`define CTIRQ_ADDR_TIMER      8'h06
`define CTIRQ_ADDR_FUNC1      8'h07
`define CTIRQ_ADDR_FUNC2      8'h08
`define CTIRQ_ADDR_IRQ_EN     8'h09
`define CTIRQ_ADDR_IRQ_FLAG   8'h0A
`define CTIRQ_RST_TIMER       8'h3D
`define CTIRQ_RST_FUNC1       8'h47
`define CTIRQ_RST_FUNC2       8'h00
`define CTIRQ_RST_IRQ_EN      8'h00
`define CTIRQ_TIMER_MASK      8'h3E
`define CTIRQ_BIT_EOC_TMR     5
`define CTIRQ_BIT_CHG_TMR     4
`define CTIRQ_BIT_CHG_LEN     3
`define CTIRQ_BIT_DOG_ON      2
`define CTIRQ_BIT_DOG_LEN     1
`define CTIRQ_BIT_DOG_KICK    0
`define CTIRQ_BIT_PROFILE     7
`define CTIRQ_BIT_PK_SD_OFF   6
`define CTIRQ_BIT_BMON        5
`define CTIRQ_BIT_THR_SRC     4
`define CTIRQ_BIT_EOC_EN      2
`define CTIRQ_BIT_TRICKLE     1
`define CTIRQ_BIT_CONV        0
`define CTIRQ_IRQ_PEAK        7
`define CTIRQ_IRQ_DOG         5
`define CTIRQ_PEAK_RUN        3'h4
// time bases: ms, second and minute tick counts at 125 MHz
`define CTIRQ_CLK_HZ          125000000
`define CTIRQ_MS_CYC          (`CTIRQ_CLK_HZ / 1000)
`define CTIRQ_DEGLITCH_MS     5'h1F
`define CTIRQ_TRK_SHORT_S     16'h001E
`define CTIRQ_TRK_LONG_S      16'h003C
`define CTIRQ_FAST_SHORT_MIN  10'h12C
`define CTIRQ_FAST_LONG_MIN   10'h258
`define CTIRQ_DOG_SHORT_S     7'h20
`define CTIRQ_DOG_LONG_S      7'h40
`define CTIRQ_DOG_GRACE_S     7'h02
`define CTIRQ_DOG_GRACE_L_S   7'h04
`define CTIRQ_SAFETY_MIN      6'h28
`endif

// file: rtl/ctirq_regs.v
// charger safety timers, functional enables and interrupt registers
`timescale 1ns/1ns
`include "ctirq_defines.vh"
module ctirq_regs #(
  parameter MS_CYC = `CTIRQ_MS_CYC
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       input_valid_level,
  input  wire       battery_sense,
  input  wire       in_charge,
  input  wire       in_trickle,
  input  wire       eoc_detect,
  input  wire       peak_limit_hit,
  input  wire [6:0] irq_events,
  output wire       temp_profile_on,
  output wire       batt_monitor_run,
  output wire       thermistor_src_run,
  output wire       eoc_allowed,
  output reg        eoc_reached,
  output wire       trickle_run,
  output wire       converter_run,
  output reg        peak_shutdown,
  output reg        peak_limit_flag,
  output reg        peak_fault,
  output reg        charge_timeout,
  output reg        dog_alarm,
  output reg        dog_expired
);
  reg [7:0]  timer_r;
  reg [7:0]  func1_r;
  reg [7:0]  func2_r;
  reg [7:0]  irq_en_r;
  reg [7:0]  irq_flag_r;
  reg [7:0]  irq_set;
  reg [1:0]  vin_sync_r;
  reg [1:0]  bat_sync_r;
  reg [1:0]  eoc_sync_r;
  reg [1:0]  pk_sync_r;
  reg        pk_prev_r;
  reg        pk_flag_d_r;
  reg        dog_alarm_d_r;
  reg [2:0]  pk_run_r;
  reg [31:0] ms_cnt_r;
  reg        ms_tick;
  reg [9:0]  sec_div_r;
  reg        sec_tick;
  reg [5:0]  min_div_r;
  reg        min_tick;
  reg [4:0]  degl_r;
  reg [15:0] trk_sec_r;
  reg [9:0]  fast_min_r;
  reg [6:0]  dog_sec_r;
  reg [5:0]  dog_min_r;
  wire       wr_timer;
  wire       wr_func1;
  wire       wr_func2;
  wire       wr_irq_en;
  wire       rd_flags;
  wire       dog_kick;
  wire       dog_run;
  wire       pk_rise;
  wire       pk_event;
  wire       dog_event;
  wire [6:0] dog_alarm_s;
  wire [6:0] dog_end_s;
  wire [15:0] trk_lim_s;
  wire [9:0] fast_lim_m;

  // address match, shared by the write strobes and the read mux
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign wr_timer  = reg_wr && hit(reg_addr, `CTIRQ_ADDR_TIMER);
  assign wr_func1  = reg_wr && hit(reg_addr, `CTIRQ_ADDR_FUNC1);
  assign wr_func2  = reg_wr && hit(reg_addr, `CTIRQ_ADDR_FUNC2);
  assign wr_irq_en = reg_wr && hit(reg_addr, `CTIRQ_ADDR_IRQ_EN);
  assign rd_flags  = reg_rd && hit(reg_addr, `CTIRQ_ADDR_IRQ_FLAG);
  assign dog_kick  = wr_timer && reg_wdata[`CTIRQ_BIT_DOG_KICK];

  // input pins cross into the clock domain
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vin_sync_r <= 2'h0;
      bat_sync_r <= 2'h0;
      eoc_sync_r <= 2'h0;
      pk_sync_r  <= 2'h0;
    end else begin
      vin_sync_r <= {vin_sync_r[0], input_valid_level};
      bat_sync_r <= {bat_sync_r[0], battery_sense};
      eoc_sync_r <= {eoc_sync_r[0], eoc_detect};
      pk_sync_r  <= {pk_sync_r[0], peak_limit_hit};
    end
  end

  // the flag register has no write path, so writes there are dropped
  // register writes; kick bit is never stored so it reads back zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_r  <= `CTIRQ_RST_TIMER & `CTIRQ_TIMER_MASK;
      func1_r  <= `CTIRQ_RST_FUNC1;
      func2_r  <= `CTIRQ_RST_FUNC2;
      irq_en_r <= `CTIRQ_RST_IRQ_EN;
    end else begin
      if (wr_timer)
        timer_r <= reg_wdata & `CTIRQ_TIMER_MASK;
      if (wr_func1)
        func1_r <= reg_wdata;
      if (wr_func2)
        func2_r <= reg_wdata;
      if (wr_irq_en)
        irq_en_r <= reg_wdata;
    end
  end

  // read data follows the address one cycle later; no strobe is needed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (hit(reg_addr, `CTIRQ_ADDR_TIMER)) begin
      reg_rdata <= timer_r;
    end else if (hit(reg_addr, `CTIRQ_ADDR_FUNC1)) begin
      reg_rdata <= func1_r;
    end else if (hit(reg_addr, `CTIRQ_ADDR_FUNC2)) begin
      reg_rdata <= func2_r;
    end else if (hit(reg_addr, `CTIRQ_ADDR_IRQ_EN)) begin
      reg_rdata <= irq_en_r;
    end else if (hit(reg_addr, `CTIRQ_ADDR_IRQ_FLAG)) begin
      reg_rdata <= irq_flag_r;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // functional enables; force bits only matter while the input is low
  assign temp_profile_on    = func1_r[`CTIRQ_BIT_PROFILE];
  assign batt_monitor_run   = vin_sync_r[1] | func1_r[`CTIRQ_BIT_BMON];
  assign thermistor_src_run = vin_sync_r[1] | func1_r[`CTIRQ_BIT_THR_SRC];
  assign eoc_allowed        = func1_r[`CTIRQ_BIT_EOC_EN];
  assign converter_run      = func1_r[`CTIRQ_BIT_CONV];
  assign trickle_run        = func1_r[`CTIRQ_BIT_TRICKLE] & in_trickle
                              & func1_r[`CTIRQ_BIT_CONV];

  // ms, second and minute time bases
  // each tick is a one-cycle pulse; second and minute ticks lag a cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_r  <= 32'h0;
      ms_tick   <= 1'b0;
      sec_div_r <= 10'h0;
      sec_tick  <= 1'b0;
      min_div_r <= 6'h0;
      min_tick  <= 1'b0;
    end else begin
      ms_tick  <= 1'b0;
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
      if (ms_cnt_r == MS_CYC - 1) begin
        ms_cnt_r <= 32'h0;
        ms_tick  <= 1'b1;
      end else begin
        ms_cnt_r <= ms_cnt_r + 32'h1;
      end
      if (ms_tick) begin
        if (sec_div_r == 10'd999) begin
          sec_div_r <= 10'h0;
          sec_tick  <= 1'b1;
        end else begin
          sec_div_r <= sec_div_r + 10'h1;
        end
      end
      if (sec_tick) begin
        if (min_div_r == 6'd59) begin
          min_div_r <= 6'h0;
          min_tick  <= 1'b1;
        end else begin
          min_div_r <= min_div_r + 6'h1;
        end
      end
    end
  end

  // end of charge: deglitch always, then the eoc timer when enabled
  // with the timer on, the end waits for the next minute tick
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      degl_r      <= 5'h0;
      eoc_reached <= 1'b0;
    end else if (!eoc_sync_r[1] || !eoc_allowed || !in_charge) begin
      degl_r      <= 5'h0;
      eoc_reached <= 1'b0;
    end else if (ms_tick && degl_r != `CTIRQ_DEGLITCH_MS) begin
      degl_r <= degl_r + 5'h1;
    end else if (degl_r == `CTIRQ_DEGLITCH_MS) begin
      eoc_reached <= !timer_r[`CTIRQ_BIT_EOC_TMR] | min_tick | eoc_reached;
    end
  end

  // trickle / fast charge safety timer
  // leaving the trickle phase clears its count; fast time starts from zero
  assign trk_lim_s  = timer_r[`CTIRQ_BIT_CHG_LEN] ? `CTIRQ_TRK_LONG_S : `CTIRQ_TRK_SHORT_S;
  assign fast_lim_m = timer_r[`CTIRQ_BIT_CHG_LEN] ? `CTIRQ_FAST_LONG_MIN
                                                  : `CTIRQ_FAST_SHORT_MIN;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trk_sec_r      <= 16'h0;
      fast_min_r     <= 10'h0;
      charge_timeout <= 1'b0;
    end else if (!timer_r[`CTIRQ_BIT_CHG_TMR] || !in_charge) begin
      trk_sec_r      <= 16'h0;
      fast_min_r     <= 10'h0;
      charge_timeout <= 1'b0;
    end else if (in_trickle) begin
      fast_min_r <= 10'h0;
      if (sec_tick && trk_sec_r < trk_lim_s)
        trk_sec_r <= trk_sec_r + 16'h1;
      if (trk_sec_r >= trk_lim_s)
        charge_timeout <= 1'b1;
    end else begin
      trk_sec_r <= 16'h0;
      if (min_tick && fast_min_r < fast_lim_m)
        fast_min_r <= fast_min_r + 10'h1;
      if (fast_min_r >= fast_lim_m)
        charge_timeout <= 1'b1;
    end
  end

  // watchdog safety timer, armed once the battery is above dead level
  // a kick in the alarm cycle wins, so the count restarts from zero
  assign dog_run     = timer_r[`CTIRQ_BIT_DOG_ON] & bat_sync_r[1];
  assign dog_alarm_s = timer_r[`CTIRQ_BIT_DOG_LEN] ? `CTIRQ_DOG_LONG_S : `CTIRQ_DOG_SHORT_S;
  assign dog_end_s   = timer_r[`CTIRQ_BIT_DOG_LEN] ?
                       (`CTIRQ_DOG_LONG_S + `CTIRQ_DOG_GRACE_L_S) :
                       (`CTIRQ_DOG_SHORT_S + `CTIRQ_DOG_GRACE_S);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dog_sec_r   <= 7'h0;
      dog_min_r   <= 6'h0;
      dog_alarm   <= 1'b0;
      dog_expired <= 1'b0;
    end else if (!dog_run || dog_kick) begin
      dog_sec_r   <= 7'h0;
      dog_min_r   <= 6'h0;
      dog_alarm   <= 1'b0;
      dog_expired <= 1'b0;
    end else begin
      if (sec_tick && dog_sec_r < dog_end_s)
        dog_sec_r <= dog_sec_r + 7'h1;
      if (min_tick && dog_min_r < `CTIRQ_SAFETY_MIN)
        dog_min_r <= dog_min_r + 6'h1;
      dog_alarm   <= (dog_sec_r >= dog_alarm_s);
      dog_expired <= (dog_sec_r >= dog_end_s) | (dog_min_r >= `CTIRQ_SAFETY_MIN);
    end
  end

  // successive peak current limits
  assign pk_rise = pk_sync_r[1] & ~pk_prev_r;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pk_prev_r       <= 1'b0;
      pk_run_r        <= 3'h0;
      peak_limit_flag <= 1'b0;
      peak_shutdown   <= 1'b0;
      peak_fault      <= 1'b0;
    end else begin
      pk_prev_r <= pk_sync_r[1];
      if (!converter_run)
        pk_run_r <= 3'h0;
      else if (pk_rise && pk_run_r != `CTIRQ_PEAK_RUN)
        pk_run_r <= pk_run_r + 3'h1;
      peak_limit_flag <= (pk_run_r == `CTIRQ_PEAK_RUN);
      if (pk_run_r == `CTIRQ_PEAK_RUN && !func1_r[`CTIRQ_BIT_PK_SD_OFF])
        peak_shutdown <= 1'b1;
      else if (!converter_run)
        peak_shutdown <= 1'b0;
      // the fault latches on the fourth limit only, so input loss can clear it
      if (pk_run_r == `CTIRQ_PEAK_RUN && !peak_limit_flag)
        peak_fault <= 1'b1;
      else if (!vin_sync_r[1])
        peak_fault <= 1'b0;
    end
  end

  // internal sources raise their flag once, on the rising edge only
  assign pk_event  = peak_limit_flag & ~pk_flag_d_r;
  assign dog_event = dog_alarm & ~dog_alarm_d_r;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pk_flag_d_r   <= 1'b0;
      dog_alarm_d_r <= 1'b0;
    end else begin
      pk_flag_d_r   <= peak_limit_flag;
      dog_alarm_d_r <= dog_alarm;
    end
  end

  // interrupt flags: set beats the clear-on-read
  always @* begin
    irq_set                  = {1'b0, irq_events[6], 1'b0, irq_events[4:0]};
    irq_set[`CTIRQ_IRQ_PEAK] = pk_event;
    irq_set[`CTIRQ_IRQ_DOG]  = dog_event;
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag_r <= 8'h00;
    end else begin
      irq_flag_r <= ((rd_flags ? 8'h00 : irq_flag_r)) | (irq_set & irq_en_r);
    end
  end

endmodule // ctirq_regs

// file: bench/ctirq_monitor.sv
// assertions on the charger register block ports
`timescale 1ns/1ns
module ctirq_monitor (
  input wire       clk,
  input wire       reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire [7:0] reg_rdata,
  input wire       in_trickle,
  input wire       temp_profile_on,
  input wire       batt_monitor_run,
  input wire       thermistor_src_run,
  input wire       eoc_allowed,
  input wire       trickle_run,
  input wire       converter_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire f1_wr = reg_wr && reg_addr == 8'h07;
  AST_PROFILE: assert property (f1_wr |=> temp_profile_on == $past(reg_wdata[7]))
    else $error("profile enable wrong");
  AST_EOC: assert property (f1_wr |=> eoc_allowed == $past(reg_wdata[2]))
    else $error("end of charge enable wrong");
  AST_CONV: assert property (f1_wr |=> converter_run == $past(reg_wdata[0]))
    else $error("converter enable wrong");
  AST_TRICKLE: assert property (trickle_run |-> converter_run && in_trickle)
    else $error("trickle runs without converter");
  AST_BMON: assert property (f1_wr && reg_wdata[5] |=> batt_monitor_run)
    else $error("battery monitor not forced");
  AST_THR: assert property (f1_wr && reg_wdata[4] |=> thermistor_src_run)
    else $error("thermistor source not forced");
  AST_STORE: assert property (reg_wr && reg_addr == 8'h08 ##1
    reg_addr == 8'h08 && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("second settings not stored");
  AST_KICK: assert property (reg_addr == 8'h06 |=>
    reg_rdata[0] == 1'b0 && reg_rdata[7:6] == 2'b00)
    else $error("timer settings unused bits read high");
  cover property (f1_wr && !reg_wdata[0]);
  cover property (trickle_run);
  cover property (reg_wr && reg_addr == 8'h06 && reg_wdata[0]);
endmodule // ctirq_monitor
bind ctirq_regs ctirq_monitor u_mon (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .in_trickle(in_trickle),
  .temp_profile_on(temp_profile_on), .batt_monitor_run(batt_monitor_run),
  .thermistor_src_run(thermistor_src_run), .eoc_allowed(eoc_allowed),
  .trickle_run(trickle_run), .converter_run(converter_run));

// file: bench/ctirq_host.sv
// host model driving the register port of the charger block
`timescale 1ns/1ns
module ctirq_host (
  input  wire       clk,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata,
  output reg        rd_valid,
  output reg  [7:0] rd_data
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not keep its value
  endtask
  task automatic rd(input [7:0] a, input clr);
    @(negedge clk);
    reg_addr = a;
    reg_rd = clr;
    @(negedge clk);
    reg_rd = 1'b0;
    rd_data = reg_rdata;
    rd_valid = 1'b1;
    @(negedge clk);
    rd_valid = 1'b0;
  endtask
endmodule // ctirq_host

// file: bench/tb.sv
// self-checking bench for the charger timer and interrupt registers
`timescale 1ns/1ns
module tb;
  reg        clk, reset_n, input_valid_level, battery_sense, in_charge, in_trickle;
  reg        eoc_detect, peak_limit_hit;
  reg  [6:0] irq_events;
  reg  [7:0] d;
  reg  [7:0] exp_q[$];
  wire [7:0] reg_addr, reg_wdata, reg_rdata, rd_data;
  wire       reg_wr, reg_rd, rd_valid, temp_profile_on, batt_monitor_run, thermistor_src_run;
  wire       eoc_allowed, eoc_reached, trickle_run, converter_run, peak_shutdown;
  wire       peak_limit_flag, peak_fault, charge_timeout, dog_alarm, dog_expired;
  integer    n_mismatch, check_count, i, cnt, cnt2;
  ctirq_host h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_valid(rd_valid), .rd_data(rd_data));
  ctirq_regs #(.MS_CYC(1)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_valid_level(input_valid_level), .battery_sense(battery_sense),
    .in_charge(in_charge), .in_trickle(in_trickle), .eoc_detect(eoc_detect),
    .peak_limit_hit(peak_limit_hit), .irq_events(irq_events),
    .temp_profile_on(temp_profile_on), .batt_monitor_run(batt_monitor_run),
    .thermistor_src_run(thermistor_src_run), .eoc_allowed(eoc_allowed),
    .eoc_reached(eoc_reached), .trickle_run(trickle_run), .converter_run(converter_run),
    .peak_shutdown(peak_shutdown), .peak_limit_flag(peak_limit_flag),
    .peak_fault(peak_fault), .charge_timeout(charge_timeout), .dog_alarm(dog_alarm),
    .dog_expired(dog_expired));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input [7:0] e, input [7:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t expected %h got %h", $time, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task rd_exp(input [7:0] a, input [7:0] e, input clr);
    exp_q.push_back(e);
    h.rd(a, clr);
  endtask
  task wait_cyc(input integer lim, input [1:0] sel);
    cnt = 0;
    while ((sel[1] ? eoc_reached : sel[0] ? dog_expired : dog_alarm) !== 1'b1 && cnt < lim) begin
      @(negedge clk);
      cnt = cnt + 1;
    end
    if (cnt >= lim) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t wait ran out", $time);
      wrap_up;
    end
  endtask
  // read results are compared against the oldest noted expectation
  always @(posedge clk) begin
    if (rd_valid)
      chk(exp_q.pop_front(), rd_data);
  end
  initial begin
    reset_n = 1'b0;
    input_valid_level = 1'b1;
    battery_sense = 1'b1;
    in_charge = 1'b0;
    in_trickle = 1'b1;
    eoc_detect = 1'b0;
    peak_limit_hit = 1'b0;
    irq_events = 7'h00;
    n_mismatch = 0;
    check_count = 0;
    d = $urandom(59826);
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    rd_exp(8'h06, 8'h3C, 1'b0);
    rd_exp(8'h07, 8'h47, 1'b0);
    rd_exp(8'h08, 8'h00, 1'b0);
    rd_exp(8'h09, 8'h00, 1'b0);
    rd_exp(8'h0A, 8'h00, 1'b0);
    $display("test reset values done");
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      h.wr(8'h08, d);
      rd_exp(8'h08, d, 1'b0);
      h.wr(8'h09, d);
      rd_exp(8'h09, d, 1'b0);
      h.wr(8'h06, d);
      rd_exp(8'h06, d & 8'h3E, 1'b0);
      h.wr(8'h07, d);
      rd_exp(8'h07, d, 1'b0);
      chk({7'h00, d[1] & d[0]}, {7'h00, trickle_run});
      chk({7'h00, d[0]}, {7'h00, converter_run});
    end
    h.wr(8'h09, 8'h00);
    h.wr(8'h0A, 8'hFF);
    rd_exp(8'h0A, 8'h00, 1'b0);
    rd_exp(8'h20, 8'h00, 1'b0);
    h.wr(8'h07, 8'h47);
    in_trickle = 1'b0;
    $display("test register access done");
    h.wr(8'h09, 8'h0F);
    irq_events = 7'h7F;
    @(negedge clk);
    irq_events = 7'h00;
    rd_exp(8'h0A, 8'h0F, 1'b1);
    h.wr(8'h09, 8'h5F);
    irq_events = 7'h40;
    @(negedge clk);
    irq_events = 7'h00;
    rd_exp(8'h0A, 8'h40, 1'b0);
    rd_exp(8'h0A, 8'h40, 1'b1);
    rd_exp(8'h0A, 8'h00, 1'b0);
    $display("test interrupt flags done");
    h.wr(8'h09, 8'h80);
    for (i = 1; i <= 4; i = i + 1) begin
      peak_limit_hit = 1'b1;
      repeat (4) @(negedge clk);
      peak_limit_hit = 1'b0;
      repeat (5) @(negedge clk);
      chk({6'h00, 1'b0, i == 4}, {6'h00, peak_shutdown, peak_limit_flag});
      chk({7'h00, i == 4}, {7'h00, peak_fault});
    end
    rd_exp(8'h0A, 8'h80, 1'b1);
    input_valid_level = 1'b0;
    h.wr(8'h07, 8'h77);
    repeat (2) @(negedge clk);
    chk(8'h03, {6'h00, batt_monitor_run, thermistor_src_run});
    chk(8'h00, {7'h00, peak_fault});
    h.wr(8'h07, 8'h47);
    @(negedge clk);
    chk(8'h00, {6'h00, batt_monitor_run, thermistor_src_run});
    input_valid_level = 1'b1;
    h.wr(8'h07, 8'h07);
    @(negedge clk);
    chk(8'h01, {7'h00, peak_shutdown});
    h.wr(8'h07, 8'h46);
    h.wr(8'h07, 8'h47);
    chk(8'h00, {6'h00, peak_shutdown, peak_limit_flag});
    $display("test peak limit done");
    in_charge = 1'b1;
    h.wr(8'h06, 8'h1C);
    h.wr(8'h07, 8'h43);
    eoc_detect = 1'b1;
    repeat (40) @(negedge clk);
    chk(8'h00, {7'h00, eoc_reached});
    h.wr(8'h07, 8'h47);
    wait_cyc(100, 2'd2);
    chk(8'h01, {7'h00, cnt >= 31 && cnt <= 36});
    eoc_detect = 1'b0;
    $display("test end of charge done");
    h.wr(8'h09, 8'h20);
    in_trickle = 1'b1;
    h.wr(8'h06, 8'h31);
    cnt = 0;
    cnt2 = 0;
    repeat (33000) begin
      @(negedge clk);
      if (dog_alarm !== 1'b0)
        cnt = cnt + 1;
      if (charge_timeout !== 1'b1)
        cnt2 = cnt2 + 1;
    end
    chk(8'h00, {7'h00, cnt != 0});
    chk(8'h01, {7'h00, cnt2 >= 28900 && cnt2 <= 30100});
    h.wr(8'h06, 8'h2D);
    wait_cyc(40000, 1'b0);
    chk(8'h01, {7'h00, cnt >= 31000 && cnt <= 33000});
    wait_cyc(5000, 1'b1);
    chk(8'h01, {7'h00, cnt >= 1000 && cnt <= 3000});
    chk(8'h00, {7'h00, charge_timeout});
    rd_exp(8'h0A, 8'h20, 1'b1);
    $display("test watchdog done");
    repeat (4) @(negedge clk);
    wrap_up;
  end
endmodule // tb
